/* hw/acc_top.sv */
// Purpose: APB control and status logic around an analog comparator
// Assumes: comparator output asynchronous, analog core outside
// Notes:   Zero wait-state APB slave; pslverr on unmapped address
`timescale 1ns/100ps
module acc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        comparator_raw_out,
  input  wire logic        retained_stop_mode,
  output logic             comparator_enable,
  output logic             reference_input_select,
  output logic             inverting_from_negative_pin,
  output logic             comparator_out_pin,
  output logic             comparator_out_pin_oe,
  output logic             compare_irq,
  output logic             wakeup_request,
  output logic             irq
);
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire         acc_wr     = psel & penable & pwrite;
  wire         acc_rd     = psel & ~penable & ~pwrite;
  wire         hit_csr    = (paddr == acc_pkg::ACC_CSR_OFF);
  wire         hit_irq    = (paddr == acc_pkg::ACC_IRQ_OFF);
  wire         hit_mask   = (paddr == acc_pkg::ACC_MASK_OFF);
  wire         mapped     = hit_csr | hit_irq | hit_mask;

  acc_pkg::acc_csr_t csr_reg;
  logic [1:0]        sts_reg;
  logic [1:0]        msk_reg;
  logic              sync1_reg;
  logic              sync2_reg;
  logic              prev_reg;
  logic [31:0]       prdata_next;

  // Synchroniser output gated to zero while disabled
  wire         cmp_en     = csr_reg[acc_pkg::ACC_EN_BIT];
  wire         cmp_live   = sync2_reg & cmp_en;
  wire         rise       = cmp_live & ~prev_reg;
  wire         fall       = ~cmp_live & prev_reg;
  wire [1:0]   edge_sel   = csr_reg.edge_sel;
  wire         sel_rise   = (edge_sel == acc_pkg::ACC_EDGE_RISE) |
                            (edge_sel == acc_pkg::ACC_EDGE_BOTH);
  wire         sel_fall   = (edge_sel != acc_pkg::ACC_EDGE_RISE);
  wire         event_hit  = cmp_en & ((rise & sel_rise) | (fall & sel_fall));
  wire         clr_flag   = acc_wr & hit_csr & pwdata[acc_pkg::ACC_FLAG_BIT];
  wire         flag_next  = event_hit | (csr_reg[acc_pkg::ACC_FLAG_BIT] & ~clr_flag);
  wire [1:0]   sts_set    = {rise, event_hit};
  wire [1:0]   sts_clr    = (acc_wr & hit_irq) ? pwdata[1:0] : 2'h0;
  wire [1:0]   sts_next   = sts_set | (sts_reg & ~sts_clr);
  wire [7:0]   csr_wval   = (pwdata[7:0] & acc_pkg::ACC_CSR_WMASK) |
                            (csr_reg & ~acc_pkg::ACC_CSR_WMASK);
  wire [7:0]   csr_view   = {csr_reg.enable, csr_reg.ref_sel, csr_reg.flag, csr_reg.ie,
                            cmp_live, csr_reg.ope, csr_reg.edge_sel};
  wire         irq_req    = flag_next & csr_reg[acc_pkg::ACC_IE_BIT];

  assign prdata_next = hit_csr  ? {24'h000000, csr_view} :
                       hit_irq  ? {30'h0, sts_reg} :
                       hit_mask ? {30'h0, msk_reg} : 32'h00000000;

  // ----------------------------------------
  // Comparator sampling
  // ----------------------------------------
  // Raw output is asynchronous; only second flop is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= comparator_raw_out;
      sync2_reg <= sync1_reg;
      prev_reg  <= cmp_live;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Stop mode only gates wakeup_request: logic keeps comparing; reset exit clears all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_reg <= acc_pkg::ACC_CSR_RESET;
      sts_reg <= acc_pkg::ACC_STS_RESET;
      msk_reg <= acc_pkg::ACC_MSK_RESET;
    end else begin
      if (acc_wr && hit_csr) begin
        csr_reg <= csr_wval;
      end
      csr_reg[acc_pkg::ACC_FLAG_BIT] <= flag_next;
      csr_reg[acc_pkg::ACC_OUT_BIT]  <= 1'b0;
      sts_reg <= sts_next;
      if (acc_wr && hit_mask) begin
        msk_reg <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready                      <= 1'b0;
      prdata                      <= 32'h00000000;
      pslverr                     <= 1'b0;
      comparator_enable           <= 1'b0;
      reference_input_select      <= 1'b0;
      inverting_from_negative_pin <= 1'b0;
      comparator_out_pin          <= 1'b0;
      comparator_out_pin_oe       <= 1'b0;
      compare_irq                 <= 1'b0;
      wakeup_request              <= 1'b0;
      irq                         <= 1'b0;
    end else begin
      pready                      <= psel & ~penable;
      pslverr                     <= psel & ~penable & ~mapped;
      prdata                      <= acc_rd ? prdata_next : 32'h00000000;
      comparator_enable           <= acc_wr & hit_csr ? csr_wval[acc_pkg::ACC_EN_BIT]
                                                      : cmp_en;
      reference_input_select      <= acc_wr & hit_csr ? csr_wval[acc_pkg::ACC_REFSEL_BIT]
                                     : csr_reg[acc_pkg::ACC_REFSEL_BIT];
      inverting_from_negative_pin <= 1'b1;
      comparator_out_pin          <= cmp_live;
      comparator_out_pin_oe       <= cmp_en & csr_reg[acc_pkg::ACC_OPE_BIT];
      compare_irq                 <= irq_req;
      wakeup_request              <= irq_req & retained_stop_mode;
      irq                         <= |(sts_next & msk_reg);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
      (csr_reg[acc_pkg::ACC_FLAG_BIT] && csr_reg[acc_pkg::ACC_IE_BIT] && !clr_flag)
      |=> compare_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq missing");

  property p_irq_masked;
    @(posedge pclk) disable iff (!presetn)
      !csr_reg[acc_pkg::ACC_IE_BIT] && !(acc_wr && hit_csr) |=> !compare_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq not masked");

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
      clr_flag && !event_hit |=> !csr_reg[acc_pkg::ACC_FLAG_BIT];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
      csr_reg[acc_pkg::ACC_FLAG_BIT] && !clr_flag |=> csr_reg[acc_pkg::ACC_FLAG_BIT];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  property p_event_sets;
    @(posedge pclk) disable iff (!presetn)
      event_hit |=> csr_reg[acc_pkg::ACC_FLAG_BIT];
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event lost");

  property p_rise_only;
    @(posedge pclk) disable iff (!presetn)
      (edge_sel == acc_pkg::ACC_EDGE_RISE) && fall |-> !event_hit;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("fall in rise mode");

  property p_disabled_zero;
    @(posedge pclk) disable iff (!presetn)
      !cmp_en |-> (csr_view[acc_pkg::ACC_OUT_BIT] == 1'b0);
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("output bit set");

  property p_sync_delay;
    @(posedge pclk) disable iff (!presetn)
      cmp_en && $stable(cmp_en) ##0 $rose(sync1_reg) |=> sync2_reg;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync lag wrong");

  property p_pin_oe;
    @(posedge pclk) disable iff (!presetn)
      !csr_reg[acc_pkg::ACC_OPE_BIT] |=> !comparator_out_pin_oe;
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin driven");

  // Sampled presetn as antecedent keeps the release edge out of these checks
  property p_enable_out;
    @(posedge pclk) disable iff (!presetn)
      acc_wr && hit_csr |=> comparator_enable == $past(pwdata[acc_pkg::ACC_EN_BIT]);
  endproperty
  a_enable_out: assert property (p_enable_out) else $error("enable pin wrong");

  property p_refsel_out;
    @(posedge pclk) disable iff (!presetn)
      acc_wr && hit_csr |=> reference_input_select == $past(pwdata[acc_pkg::ACC_REFSEL_BIT]);
  endproperty
  a_refsel_out: assert property (p_refsel_out) else $error("reference select wrong");

  property p_neg_pin;
    @(posedge pclk) disable iff (!presetn)
      presetn |=> inverting_from_negative_pin;
  endproperty
  a_neg_pin: assert property (p_neg_pin) else $error("negative pin not routed");

  property p_no_disabled_event;
    @(posedge pclk) disable iff (!presetn)
      !cmp_en |-> !event_hit;
  endproperty
  a_no_disabled_event: assert property (p_no_disabled_event) else $error("event while off");

  property p_no_steady_event;
    @(posedge pclk) disable iff (!presetn)
      cmp_live == prev_reg |-> !event_hit;
  endproperty
  a_no_steady_event: assert property (p_no_steady_event) else $error("event without edge");

  property p_irq_quiet;
    @(posedge pclk) disable iff (!presetn)
      !csr_reg[acc_pkg::ACC_FLAG_BIT] && !event_hit |=> !compare_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without flag");

  property p_live_read;
    @(posedge pclk) disable iff (!presetn)
      acc_rd && hit_csr |=> prdata[acc_pkg::ACC_OUT_BIT] == $past(cmp_live);
  endproperty
  a_live_read: assert property (p_live_read) else $error("output bit read wrong");

  property p_out_bit_zero;
    @(posedge pclk) disable iff (!presetn)
      presetn |=> !csr_reg[acc_pkg::ACC_OUT_BIT];
  endproperty
  a_out_bit_zero: assert property (p_out_bit_zero) else $error("stored output bit set");

  property p_pin_drive;
    @(posedge pclk) disable iff (!presetn)
      cmp_en && csr_reg[acc_pkg::ACC_OPE_BIT] |=> comparator_out_pin_oe;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not driven");

  property p_pin_value;
    @(posedge pclk) disable iff (!presetn)
      presetn |=> comparator_out_pin == $past(cmp_live);
  endproperty
  a_pin_value: assert property (p_pin_value) else $error("pin value wrong");

  property p_rise_mode;
    @(posedge pclk) disable iff (!presetn)
      ((edge_sel == acc_pkg::ACC_EDGE_RISE) || (edge_sel == acc_pkg::ACC_EDGE_BOTH))
      && cmp_en && rise |-> event_hit;
  endproperty
  a_rise_mode: assert property (p_rise_mode) else $error("rise not flagged");

  property p_fall_mode;
    @(posedge pclk) disable iff (!presetn)
      ((edge_sel == acc_pkg::ACC_EDGE_FALL0) || (edge_sel == acc_pkg::ACC_EDGE_FALL2) ||
       (edge_sel == acc_pkg::ACC_EDGE_BOTH)) && cmp_en && fall |-> event_hit;
  endproperty
  a_fall_mode: assert property (p_fall_mode) else $error("fall not flagged");

  property p_raw_polarity;
    @(posedge pclk) disable iff (!presetn)
      presetn |=> sync1_reg == $past(comparator_raw_out);
  endproperty
  a_raw_polarity: assert property (p_raw_polarity) else $error("output inverted");

  property p_wake_set;
    @(posedge pclk) disable iff (!presetn)
      irq_req && retained_stop_mode |=> wakeup_request;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wakeup missing");

  property p_wake_off;
    @(posedge pclk) disable iff (!presetn)
      !retained_stop_mode |=> !wakeup_request;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wakeup outside stop");
endmodule

/* hw/acc_pkg.sv */
// Purpose: Constants and types for the analog comparator control block
// Assumes: APB slave, 32-bit data, 25 MHz pclk
// Notes:   Control byte in low 8 bits of word 0x0
package acc_pkg;
  localparam logic [11:0] ACC_CSR_OFF    = 12'h000;
  localparam logic [11:0] ACC_IRQ_OFF    = 12'h004;
  localparam logic [11:0] ACC_MASK_OFF   = 12'h008;
  localparam int          ACC_EN_BIT     = 7;
  localparam int          ACC_REFSEL_BIT = 6;
  localparam int          ACC_FLAG_BIT   = 5;
  localparam int          ACC_IE_BIT     = 4;
  localparam int          ACC_OUT_BIT    = 3;
  localparam int          ACC_OPE_BIT    = 2;
  localparam logic [7:0]  ACC_CSR_RESET  = 8'h00;
  localparam logic [7:0]  ACC_CSR_WMASK  = 8'hD7;
  localparam logic [1:0]  ACC_STS_RESET  = 2'h0;
  localparam logic [1:0]  ACC_MSK_RESET  = 2'h0;

  typedef enum logic [1:0] {
    ACC_EDGE_FALL0 = 2'b00,
    ACC_EDGE_RISE  = 2'b01,
    ACC_EDGE_FALL2 = 2'b10,
    ACC_EDGE_BOTH  = 2'b11
  } acc_edge_t;

  // Status bits: [0] compare event, [1] output rise seen
  typedef struct packed {
    logic       enable;
    logic       ref_sel;
    logic       flag;
    logic       ie;
    logic       out_val;
    logic       ope;
    acc_edge_t  edge_sel;
  } acc_csr_t;
endpackage

/* bench/acc_core_model.sv */
// Purpose: Behavioural analog comparator core
// Assumes: Voltages in millivolts
// Notes:   No hysteresis; equal inputs read low
`timescale 1ns/100ps
module acc_core_model #(
  parameter int BANDGAP_MV = 1200
) (
  input  wire logic enable,
  input  wire logic ref_sel,
  input  wire logic neg_pin_inv,
  input  int        pos_mv,
  input  int        neg_mv,
  output logic      raw_out
);
  // ----------
  // Compare
  // ----------
  int noninv_mv;
  assign noninv_mv = ref_sel ? BANDGAP_MV : pos_mv;
  // Disabled core held low, not floating
  assign raw_out = enable & neg_pin_inv & (noninv_mv > neg_mv);
endmodule

/* bench/acc_top_tb_top.sv */
// Purpose: Self-checking bench for acc_top
// Assumes: APB master, behavioural comparator core
// Notes:   Expected APB answers queued, popped by monitor
`timescale 1ns/100ps
module acc_top_tb_top;
  localparam logic [11:0] CSR = 12'h000;
  localparam logic [11:0] STS = 12'h004;
  localparam logic [11:0] MSK = 12'h008;
  logic        pclk, pready, pslverr, raw, en, rsel, ninv, pin, oe, cirq, wake, irq, cur, prv, fl;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_m = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  int          pos = 1000, neg = 2500, fail_count, samples_checked, k, p;
  logic [32:0] exq[$];
  logic [15:0] lvq[$], lq;
  acc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .comparator_raw_out(raw), .retained_stop_mode(stop_m),
    .comparator_enable(en), .reference_input_select(rsel),
    .inverting_from_negative_pin(ninv), .comparator_out_pin(pin),
    .comparator_out_pin_oe(oe), .compare_irq(cirq), .wakeup_request(wake), .irq(irq));
  acc_core_model core (.enable(en), .ref_sel(rsel), .neg_pin_inv(ninv), .pos_mv(pos),
    .neg_mv(neg), .raw_out(raw));
  wire  [7:0]  outs = {en, rsel, ninv, pin, oe, cirq, wake, irq};
  // ----------
  // Tasks
  // ----------
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] e, input logic err = 1'b0);
    @(posedge pclk);
    exq.push_back({err, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt;
    repeat (6) @(posedge pclk);
  endtask
  task automatic lvl(input logic [7:0] m, input logic [7:0] e);
    lvq.push_back({m, e});
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------
  // Clock, watchdog, monitor
  // ----------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end
  always @(posedge pclk) begin
    if (psel && penable && pready && exq.size() > 0) begin
      chk({pslverr, prdata}, exq.pop_front());
    end
    if (lvq.size() > 0) begin
      lq = lvq.pop_front();
      chk({25'h0, lq[15:8] & outs}, {25'h0, lq[15:8] & lq[7:0]});
    end
  end
  // ----------
  // Scenarios
  // ----------
  initial begin
    void'($urandom(32'h7457));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(CSR, 0, 0, 0);
    apb(12'h00C, 0, 0, 0, 1'b1);
    for (k = 0; k < 4; k++) begin
      apb(CSR, 1, 32'h80 | k, 0);
      pos <= 4000;
      wt();
      apb(CSR, 0, 0, 32'h88 | k | ((k % 2 == 1) ? 32'h20 : 32'h0));
      apb(CSR, 1, 32'hA0 | k, 0);
      pos <= 1000;
      wt();
      apb(CSR, 0, 0, 32'h80 | k | ((k != 1) ? 32'h20 : 32'h0));
      apb(CSR, 1, 32'hA0 | k, 0);
    end
    apb(CSR, 1, 32'h91, 0);
    stop_m <= 1'b1;
    pos <= 4000;
    wt();
    lvl(8'h04, 8'h04);
    lvl(8'h02, 8'h02);
    apb(CSR, 1, 32'h81, 0);
    apb(CSR, 0, 0, 32'hA9);
    wt();
    lvl(8'h04, 8'h00);
    lvl(8'h01, 8'h00);
    apb(MSK, 1, 1, 0);
    wt();
    lvl(8'h01, 8'h01);
    apb(STS, 1, 3, 0);
    wt();
    lvl(8'h01, 8'h00);
    apb(CSR, 1, 32'hA4, 0);
    wt();
    lvl(8'h18, 8'h18);
    apb(CSR, 1, 32'h24, 0);
    wt();
    apb(CSR, 0, 0, 32'h04);
    lvl(8'h98, 8'h00);
    apb(CSR, 1, 32'hC4, 0);
    pos <= 0;
    neg <= 1000;
    wt();
    lvl(8'hF8, 8'hF8);
    apb(CSR, 1, 32'h80, 0);
    wt();
    apb(CSR, 1, 32'hA0, 0);
    neg <= 2500;
    prv = 1'b0;
    fl = 1'b0;
    for (k = 0; k < 6; k++) begin
      p = $urandom_range(4900, 100);
      if (p == 2500) p++;
      pos <= p;
      cur = (p > 2500);
      fl = fl | (prv & ~cur);
      prv = cur;
      wt();
      apb(CSR, 0, 0, {24'h0, 2'b10, fl, 1'b0, cur, 3'b000});
    end
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(CSR, 0, 0, 0);
    lvl(8'hFF, 8'h20);
    wt();
    end_sim();
  end
endmodule
